// ### frl_pkg.sv
// Constants, register map and types of the frequency reference limiter
package frl_pkg;
  // ==========================================================================
  // How it works
  // - Stop method takes 0 to 4; free-run at 2 drops the drive at once.
  // - Power braking (4) holds or reaccelerates while the DC bus is over its limit.
  // - Braking and stall holds act only in deceleration; power braking wins.
  // - Requests below the start frequency become zero; start is 0.01 to 10.00 Hz.
  // - Every selection is clamped to the maximum, which is 40.00 to 400.00 Hz.
  // - Keypad references pass the same start and maximum limits as the others.
  // - Limit enable is off at reset; on adds a lower and upper window.
  // - Lower limit resets to 0.50 Hz, up to maximum; upper resets to maximum.
  // - With the window on, speed settings except nominal clamp to the upper limit.
  // - With jump on, output never rests inside a jump band, whatever the source.
  // - A rising setting inside a band holds at the band floor until above it.
  // - Three bands, skipped both ways; defaults 10-15, 20-25 and 30-35 Hz.
  // - Decelerate stop ramps the output down to zero hertz, then stops.

  // ==========================================================================
  // Widths and timing (frequencies in steps of 0.01 Hz)
  localparam int          FREQ_W          = 16;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          NUM_BANDS       = 3;
  localparam int          CLK_MHZ         = 100;
  localparam int          RAMP_TICK_US    = 10;
  localparam int          RAMP_TICK_CYC   = RAMP_TICK_US * CLK_MHZ;
  localparam logic [15:0] RAMP_STEP       = 16'h0001;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_LOWEST      = 8'h04;
  localparam logic [7:0]  OFS_TOP         = 8'h08;
  localparam logic [7:0]  OFS_WIN_LO      = 8'h0C;
  localparam logic [7:0]  OFS_WIN_HI      = 8'h10;
  localparam logic [7:0]  OFS_NOMINAL     = 8'h14;
  localparam logic [7:0]  OFS_BAND_BASE   = 8'h18;
  localparam logic [7:0]  OFS_KEYPAD      = 8'h30;
  localparam logic [7:0]  OFS_STATUS      = 8'h34;
  localparam logic [7:0]  OFS_OUT_FREQ    = 8'h38;
  localparam logic [7:0]  OFS_TARGET      = 8'h3C;

  // ==========================================================================
  // Control register fields
  localparam int          CTRL_STOP_LSB   = 0;
  localparam int          CTRL_WIN_EN     = 4;
  localparam int          CTRL_JUMP_EN    = 5;
  localparam int          CTRL_STALL_SEL  = 6;
  localparam int          CTRL_KEY_SRC    = 7;
  localparam int          CTRL_REACCEL    = 8;
  localparam logic [2:0]  STOP_DECEL      = 3'h0;
  localparam logic [2:0]  STOP_FREE_RUN   = 3'h2;
  localparam logic [2:0]  STOP_PBRAKE     = 3'h4;
  localparam logic [2:0]  STOP_MAX        = 3'h4;

  // ==========================================================================
  // Setting ranges and reset values
  localparam logic [15:0] LOWEST_MIN      = 16'h0001;
  localparam logic [15:0] LOWEST_MAX      = 16'h03E8;
  localparam logic [15:0] LOWEST_RST      = 16'h0032;
  localparam logic [15:0] TOP_MIN         = 16'h0FA0;
  localparam logic [15:0] TOP_MAX         = 16'h9C40;
  localparam logic [15:0] TOP_RST         = 16'h1770;
  localparam logic [15:0] WIN_LO_RST      = 16'h0032;
  localparam logic [15:0] NOMINAL_RST     = 16'h1770;
  localparam logic [15:0] BAND_FLOOR_RST [NUM_BANDS] = '{16'h03E8, 16'h07D0, 16'h0BB8};
  localparam logic [15:0] BAND_CEIL_RST  [NUM_BANDS] = '{16'h05DC, 16'h09C4, 16'h0DAC};

  // ==========================================================================
  // Drive state
  typedef enum logic [1:0] {
    FRL_IDLE,
    FRL_RUN,
    FRL_STOPPING
  } frl_state_t;
endpackage

// ### frl_limiter.sv
// Frequency reference limiter with jump bands, ramp and stop selection
module frl_limiter #(
  parameter int RAMP_TICK_CYCLES = frl_pkg::RAMP_TICK_CYC
) (
  // Clock and reset
  input  wire logic                        mclk_in,
  input  wire logic                        arst_n_in,
  // Register port
  input  wire logic [frl_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [frl_pkg::DATA_W-1:0]  wr_data_in,
  input  wire logic                        wr_in,
  input  wire logic                        rd_in,
  output logic      [frl_pkg::DATA_W-1:0]  rd_data_out,
  // Drive control
  input  wire logic                        run_in,
  input  wire logic [frl_pkg::FREQ_W-1:0]  ext_ref_in,
  input  wire logic                        dc_over_in,
  input  wire logic                        stall_in,
  // Drive outputs
  output logic                             drive_en_out,
  output logic      [frl_pkg::FREQ_W-1:0]  out_freq_out,
  output logic                             decel_out,
  output logic                             pbrake_act_out,
  output logic                             stall_act_out
);

  // ==========================================================================
  // Settings
  logic [2:0]                 stop_method;
  logic                       win_en;
  logic                       jump_en;
  logic                       stall_guard_select;
  logic                       key_src;
  logic                       reaccel_sel;
  logic [15:0]                lowest_run_frequency;
  logic [15:0]                top_frequency;
  logic [15:0]                win_lo;
  logic [15:0]                win_hi;
  logic [15:0]                nominal_motor_frequency;
  logic [15:0]                keypad_ref;
  logic [15:0]                band_floor [frl_pkg::NUM_BANDS];
  logic [15:0]                band_ceil  [frl_pkg::NUM_BANDS];

  // Datapath
  frl_pkg::frl_state_t        state;
  logic [15:0]                target;
  logic [15:0]                next_target;
  logic [15:0]                clamped;
  logic [15:0]                prev_clamped;
  logic                       rising;
  logic                       jump_hold;
  logic [15:0]                ramp_next;
  logic [15:0]                skip_next;
  logic                       ramp_tick;
  logic [31:0]                tick_cnt;
  logic [1:0]                 dc_sync;
  logic [1:0]                 stall_sync;
  logic                       dir_up;
  logic                       decelerating;
  logic [frl_pkg::NUM_BANDS-1:0] in_band;
  logic [frl_pkg::NUM_BANDS-1:0] ramp_in_band;
  logic [15:0]                wr_val;

  assign wr_val = wr_data_in[15:0];

  // Clamp a written speed setting to maximum, and to the window top if enabled
  function automatic logic [15:0] clamp_speed(input logic [15:0] v, input logic [15:0] top,
                                              input logic en, input logic [15:0] hi);
    logic [15:0] r;
    r = (v > top) ? top : v;
    return (en && (r > hi)) ? hi : r;
  endfunction

  // ==========================================================================
  // Pin synchronisers: comparator flags arrive from the analog side
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dc_sync    <= 2'h0;
      stall_sync <= 2'h0;
    end else begin
      dc_sync    <= {dc_sync[0], dc_over_in};
      stall_sync <= {stall_sync[0], stall_in};
    end
  end

  // ==========================================================================
  // Control register writes
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stop_method        <= frl_pkg::STOP_DECEL;
      win_en             <= 1'b0;
      jump_en            <= 1'b0;
      stall_guard_select <= 1'b0;
      key_src            <= 1'b0;
      reaccel_sel        <= 1'b0;
    end else if (wr_in && (addr_in == frl_pkg::OFS_CTRL)) begin
      // Out-of-range stop codes keep the previous method
      if (wr_data_in[frl_pkg::CTRL_STOP_LSB +: 3] <= frl_pkg::STOP_MAX) begin
        stop_method <= wr_data_in[frl_pkg::CTRL_STOP_LSB +: 3];
      end
      win_en             <= wr_data_in[frl_pkg::CTRL_WIN_EN];
      jump_en            <= wr_data_in[frl_pkg::CTRL_JUMP_EN];
      stall_guard_select <= wr_data_in[frl_pkg::CTRL_STALL_SEL];
      key_src            <= wr_data_in[frl_pkg::CTRL_KEY_SRC];
      reaccel_sel        <= wr_data_in[frl_pkg::CTRL_REACCEL];
    end
  end

  // Start and maximum frequency, kept inside their documented ranges
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lowest_run_frequency <= frl_pkg::LOWEST_RST;
      top_frequency        <= frl_pkg::TOP_RST;
    end else if (wr_in) begin
      if (addr_in == frl_pkg::OFS_LOWEST) begin
        if (wr_val < frl_pkg::LOWEST_MIN) begin
          lowest_run_frequency <= frl_pkg::LOWEST_MIN;
        end else if (wr_val > frl_pkg::LOWEST_MAX) begin
          lowest_run_frequency <= frl_pkg::LOWEST_MAX;
        end else begin
          lowest_run_frequency <= clamp_speed(wr_val, top_frequency, win_en, win_hi);
        end
      end
      if (addr_in == frl_pkg::OFS_TOP) begin
        if (wr_val < frl_pkg::TOP_MIN) begin
          top_frequency <= frl_pkg::TOP_MIN;
        end else if (wr_val > frl_pkg::TOP_MAX) begin
          top_frequency <= frl_pkg::TOP_MAX;
        end else begin
          top_frequency <= wr_val;
        end
      end
    end
  end

  // Window limits, nominal frequency and keypad reference
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      win_lo                  <= frl_pkg::WIN_LO_RST;
      win_hi                  <= frl_pkg::TOP_RST;
      nominal_motor_frequency <= frl_pkg::NOMINAL_RST;
      keypad_ref              <= 16'h0000;
    end else if (wr_in) begin
      if (addr_in == frl_pkg::OFS_WIN_LO) begin
        win_lo <= clamp_speed(wr_val, top_frequency, win_en, win_hi);
      end
      if (addr_in == frl_pkg::OFS_WIN_HI) begin
        win_hi <= (wr_val > top_frequency) ? top_frequency : wr_val;
      end
      if (addr_in == frl_pkg::OFS_NOMINAL) begin
        // Nominal is exempt from the window top, only the maximum binds it
        nominal_motor_frequency <= (wr_val > top_frequency) ? top_frequency : wr_val;
      end
      if (addr_in == frl_pkg::OFS_KEYPAD) begin
        keypad_ref <= clamp_speed(wr_val, top_frequency, win_en, win_hi);
      end
    end
  end

  // ==========================================================================
  // Jump bands: register pair and membership tests per band
  generate
    for (genvar b = 0; b < frl_pkg::NUM_BANDS; b++) begin : g_band
      localparam logic [7:0] OFS_FLOOR = frl_pkg::OFS_BAND_BASE + 8'(8 * b);
      localparam logic [7:0] OFS_CEIL  = frl_pkg::OFS_BAND_BASE + 8'(8 * b + 4);

      always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          band_floor[b] <= frl_pkg::BAND_FLOOR_RST[b];
          band_ceil[b]  <= frl_pkg::BAND_CEIL_RST[b];
        end else if (wr_in && (addr_in == OFS_FLOOR)) begin
          // Floor may not pass its own ceiling
          band_floor[b] <= (wr_val > band_ceil[b]) ? band_ceil[b]
                         : clamp_speed(wr_val, top_frequency, win_en, win_hi);
        end else if (wr_in && (addr_in == OFS_CEIL)) begin
          band_ceil[b] <= (wr_val < band_floor[b]) ? band_floor[b]
                        : clamp_speed(wr_val, top_frequency, win_en, win_hi);
        end
      end

      // Setting on or inside the band edges, ramp value strictly inside
      assign in_band[b]      = (clamped >= band_floor[b]) && (clamped <= band_ceil[b]);
      assign ramp_in_band[b] = (ramp_next > band_floor[b]) && (ramp_next < band_ceil[b]);
    end
  endgenerate

  // ==========================================================================
  // Reference chain: source, maximum, window, start
  always_comb begin
    clamped = key_src ? keypad_ref : ext_ref_in;
    clamped = (clamped > top_frequency) ? top_frequency : clamped;
    clamped = (win_en && (clamped > win_hi)) ? win_hi : clamped;
    clamped = (win_en && (clamped < win_lo)) ? win_lo : clamped;
    clamped = (clamped < lowest_run_frequency) ? 16'h0000 : clamped;
  end

  // Jump holding after clamping, by this cycle's direction; lowest band has priority
  assign dir_up = (clamped > prev_clamped) || ((clamped == prev_clamped) && rising);
  always_comb begin
    next_target = clamped;
    jump_hold   = 1'b0;
    for (int b = frl_pkg::NUM_BANDS - 1; b >= 0; b--) begin
      if (jump_en && in_band[b]) begin
        next_target = dir_up ? band_floor[b] : band_ceil[b];
        jump_hold   = 1'b1;
      end
    end
  end

  // Direction of the setting; an unchanged value keeps the last direction
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prev_clamped <= 16'h0000;
      rising       <= 1'b1;
      target       <= 16'h0000;
    end else begin
      prev_clamped <= clamped;
      rising       <= dir_up;
      target <= next_target;
    end
  end

  // ==========================================================================
  // Ramp tick divider
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_cnt  <= 32'h00000000;
      ramp_tick <= 1'b0;
    end else begin
      ramp_tick <= (tick_cnt >= 32'(RAMP_TICK_CYCLES - 1));
      tick_cnt  <= (tick_cnt >= 32'(RAMP_TICK_CYCLES - 1)) ? 32'h00000000
                                                           : tick_cnt + 32'h00000001;
    end
  end

  // ==========================================================================
  // Ramp step with braking and stall holds
  logic [15:0] goal;
  assign goal         = (state == frl_pkg::FRL_RUN) ? target : 16'h0000;
  assign decelerating = (out_freq_out > goal);

  always_comb begin
    pbrake_act_out = decelerating && (stop_method == frl_pkg::STOP_PBRAKE) && dc_sync[1];
    stall_act_out  = decelerating && stall_guard_select && stall_sync[1]
                     && !pbrake_act_out;
    ramp_next      = out_freq_out; // Braking and stall holds keep this value
    if (out_freq_out < goal) begin
      ramp_next = ((goal - out_freq_out) > frl_pkg::RAMP_STEP) ?
                  out_freq_out + frl_pkg::RAMP_STEP : goal;
    end else if (pbrake_act_out) begin
      // Reaccelerate briefly or just flatten the slope to cut regeneration
      if (reaccel_sel && (out_freq_out < top_frequency)) begin
        ramp_next = out_freq_out + frl_pkg::RAMP_STEP;
      end
    end else if (decelerating && !stall_act_out) begin
      ramp_next = ((out_freq_out - goal) > frl_pkg::RAMP_STEP) ?
                  out_freq_out - frl_pkg::RAMP_STEP : goal;
    end
  end

  // A ramp value landing inside a band is pushed across it in the travel direction
  always_comb begin
    skip_next = ramp_next;
    for (int b = 0; b < frl_pkg::NUM_BANDS; b++) begin
      if (jump_en && ramp_in_band[b]) begin
        skip_next = (ramp_next > out_freq_out) ? band_ceil[b] : band_floor[b];
      end
    end
  end

  // ==========================================================================
  // Run and stop sequencing
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state        <= frl_pkg::FRL_IDLE;
      out_freq_out <= 16'h0000;
      drive_en_out <= 1'b0;
      decel_out    <= 1'b0;
    end else begin
      unique case (state)
        frl_pkg::FRL_IDLE: begin
          out_freq_out <= 16'h0000;
          decel_out    <= 1'b0;
          if (run_in) begin
            state        <= frl_pkg::FRL_RUN;
            drive_en_out <= 1'b1;
          end
        end
        frl_pkg::FRL_RUN: begin
          if (!run_in && (stop_method == frl_pkg::STOP_FREE_RUN)) begin
            // No controlled stop: the load coasts on its own inertia
            state        <= frl_pkg::FRL_IDLE;
            drive_en_out <= 1'b0;
            out_freq_out <= 16'h0000;
            decel_out    <= 1'b0;
          end else begin
            if (!run_in) begin
              state <= frl_pkg::FRL_STOPPING;
            end
            if (ramp_tick) begin
              out_freq_out <= skip_next;
            end
            decel_out <= decelerating;
          end
        end
        frl_pkg::FRL_STOPPING: begin
          decel_out <= 1'b1;
          if (run_in) begin
            state <= frl_pkg::FRL_RUN;
          end else if (stop_method == frl_pkg::STOP_FREE_RUN) begin
            state        <= frl_pkg::FRL_IDLE;
            drive_en_out <= 1'b0;
            out_freq_out <= 16'h0000;
          end else if (out_freq_out == 16'h0000) begin
            state        <= frl_pkg::FRL_IDLE;
            drive_en_out <= 1'b0;
          end else if (ramp_tick) begin
            out_freq_out <= skip_next;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Register readback, one cycle after the read strobe
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_out <= 32'h00000000;
    end else if (rd_in) begin
      rd_data_out <= 32'h00000000;
      unique case (addr_in)
        frl_pkg::OFS_CTRL:     rd_data_out <= {23'h000000, reaccel_sel, key_src,
                                               stall_guard_select, jump_en, win_en,
                                               1'b0, stop_method};
        frl_pkg::OFS_LOWEST:   rd_data_out <= {16'h0000, lowest_run_frequency};
        frl_pkg::OFS_TOP:      rd_data_out <= {16'h0000, top_frequency};
        frl_pkg::OFS_WIN_LO:   rd_data_out <= {16'h0000, win_lo};
        frl_pkg::OFS_WIN_HI:   rd_data_out <= {16'h0000, win_hi};
        frl_pkg::OFS_NOMINAL:  rd_data_out <= {16'h0000, nominal_motor_frequency};
        frl_pkg::OFS_KEYPAD:   rd_data_out <= {16'h0000, keypad_ref};
        frl_pkg::OFS_STATUS:   rd_data_out <= {26'h0000000, jump_hold, stall_act_out,
                                               pbrake_act_out, decel_out, drive_en_out,
                                               state == frl_pkg::FRL_RUN};
        frl_pkg::OFS_OUT_FREQ: rd_data_out <= {16'h0000, out_freq_out};
        frl_pkg::OFS_TARGET:   rd_data_out <= {16'h0000, target};
        default: begin
          // Band registers decode from the base; other addresses read zero
          for (int b = 0; b < frl_pkg::NUM_BANDS; b++) begin
            if (addr_in == frl_pkg::OFS_BAND_BASE + 8'(8 * b)) begin
              rd_data_out <= {16'h0000, band_floor[b]};
            end
            if (addr_in == frl_pkg::OFS_BAND_BASE + 8'(8 * b + 4)) begin
              rd_data_out <= {16'h0000, band_ceil[b]};
            end
          end
        end
      endcase
    end
  end

endmodule

// ### frl_limiter_sva.sv
// Port checker of the frequency reference limiter
module frl_limiter_sva #(
  parameter int RAMP_TICK_CYCLES = 1000
) (
  input wire logic        mclk_in,
  input wire logic        arst_n_in,
  input wire logic [7:0]  addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rd_data_out,
  input wire logic        run_in,
  input wire logic        drive_en_out,
  input wire logic [15:0] out_freq_out,
  input wire logic        pbrake_act_out,
  input wire logic        stall_act_out
);
  logic [8:0] ctl;
  // ==========================================================================
  // Shadow of the control word; a stop code above four keeps the old one
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctl <= 9'h000;
    end else if (wr_in && addr_in == frl_pkg::OFS_CTRL) begin
      ctl[8:3] <= wr_data_in[8:3];
      if (wr_data_in[2:0] <= frl_pkg::STOP_MAX) ctl[2:0] <= wr_data_in[2:0];
    end
  end
  // Reset band edges only; the bench never moves them
  function automatic logic in_band(input logic [15:0] f);
    in_band = 1'b0;
    for (int i = 0; i < frl_pkg::NUM_BANDS; i++) begin
      if (f > frl_pkg::BAND_FLOOR_RST[i] && f < frl_pkg::BAND_CEIL_RST[i]) in_band = 1'b1;
    end
  endfunction
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  // ==========================================================================
  // Properties
  chk_top_bound: assert property (out_freq_out <= frl_pkg::TOP_RST)
    else $error("output above maximum");
  chk_free_run_drop: assert property (drive_en_out && !run_in && ctl[2:0] == 3'h2
    |=> !drive_en_out && out_freq_out == 16'h0000) else $error("free-run did not drop");
  chk_off_zero: assert property (!drive_en_out |-> out_freq_out == 16'h0000)
    else $error("frequency while output off");
  chk_stop_at_zero: assert property ($fell(drive_en_out) && ctl[2:0] != 3'h2
    |-> $past(out_freq_out) == 16'h0000) else $error("stopped above zero");
  chk_run_starts: assert property ($rose(run_in) && !drive_en_out |=> drive_en_out)
    else $error("run did not enable output");
  chk_brake_wins: assert property (!(pbrake_act_out && stall_act_out))
    else $error("stall hold beside braking");
  chk_brake_mode: assert property (pbrake_act_out && !ctl[8]
    |-> ctl[2:0] == 3'h4 ##1 $stable(out_freq_out)) else $error("braking hold wrong");
  chk_stall_hold: assert property (stall_act_out |-> ctl[6] ##1 $stable(out_freq_out))
    else $error("stall hold wrong");
  chk_ramp_unit: assert property (drive_en_out && $past(drive_en_out) && !ctl[5]
    |-> out_freq_out - $past(out_freq_out) inside {16'h0000, 16'h0001, 16'hFFFF})
    else $error("ramp step not one");
  chk_no_band: assert property (drive_en_out && ctl[5] |-> !in_band(out_freq_out))
    else $error("output inside jump band");
  chk_unmapped_zero: assert property (rd_in && addr_in == 8'h40 |=> rd_data_out == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind frl_limiter frl_limiter_sva #(.RAMP_TICK_CYCLES(RAMP_TICK_CYCLES)) u_sva (
  .mclk_in(mclk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .run_in(run_in),
  .drive_en_out(drive_en_out), .out_freq_out(out_freq_out),
  .pbrake_act_out(pbrake_act_out), .stall_act_out(stall_act_out));

// ### frl_motor_model.sv
// Motor model: regenerates while braked and may stall
module frl_motor_model (
  input  wire logic mclk_in,
  input  wire logic drive_en_in,
  input  wire logic decel_in,
  input  wire logic regen_en_in,
  input  wire logic stall_en_in,
  output logic      dc_over_out = 1'b0,
  output logic      stall_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus voltage only rises while a driven motor is slowed down
  always @(posedge mclk_in) begin
    dc_over_out <= regen_en_in && drive_en_in && decel_in;
    stall_out   <= stall_en_in && drive_en_in;
  end
endmodule

// ### frl_limiter_tb.sv
// Self-checking bench of the frequency reference limiter
module frl_limiter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 4;
  logic mclk_in = 1'b0, arst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, run_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wr_data_in = 32'h0, rd_data_out;
  logic [15:0] ext_ref_in = 16'h0, out_freq_out;
  logic regen = 1'b0, stall_en = 1'b0, dc_over_in, stall_in;
  logic drive_en_out, decel_out, pbrake_act_out, stall_act_out;
  int num_errors = 0, compares = 0, cycles = 0;
  frl_limiter #(.RAMP_TICK_CYCLES(TICK)) DUT (.mclk_in, .arst_n_in, .addr_in, .wr_data_in,
    .wr_in, .rd_in, .rd_data_out, .run_in, .ext_ref_in, .dc_over_in, .stall_in,
    .drive_en_out, .out_freq_out, .decel_out, .pbrake_act_out, .stall_act_out);
  frl_motor_model u_motor (.mclk_in(mclk_in), .drive_en_in(drive_en_out), .decel_in(decel_out),
    .regen_en_in(regen), .stall_en_in(stall_en), .dc_over_out(dc_over_in), .stall_out(stall_in));
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  // Hang guard; the run needs a few thousand cycles
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict;
    end
  end
  // ==========================================================================
  // Bus and compare helpers; a gap cycle keeps each strobe a clean pulse
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wr_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    cyc(1);
    wr_in <= 1'b0;
    cyc(1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd_in <= 1'b1;
    addr_in <= a;
    cyc(1);
    rd_in <= 1'b0;
    #1 chk(rd_data_out, exp);
    cyc(1);
  endtask
  task automatic refc(input logic [15:0] r, input logic [31:0] exp);
    ext_ref_in <= r;
    cyc(3);
    rdc(frl_pkg::OFS_TARGET, exp);
  endtask
  task automatic waitf(input logic [15:0] f, input int n);
    repeat (n) if (out_freq_out !== f) @(posedge mclk_in);
    chk({16'h0, out_freq_out}, {16'h0, f});
  endtask
  task automatic waitb(input bit brk, input int n);
    repeat (n) if ((brk ? pbrake_act_out : stall_act_out) !== 1'b1) @(posedge mclk_in);
    chk({31'h0, brk ? pbrake_act_out : stall_act_out}, 32'h1);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_defaults;
    logic [31:0] exp [12] = '{32'h0, 32'h32, 32'h1770, 32'h32, 32'h1770, 32'h1770,
      32'h3E8, 32'h5DC, 32'h7D0, 32'h9C4, 32'hBB8, 32'hDAC};
    for (int i = 0; i < 12; i++) rdc(8'(i * 4), exp[i]);
    rdc(8'h40, 32'h0);
  endtask
  task automatic t_clamps;
    wr(frl_pkg::OFS_LOWEST, 32'h0);
    rdc(frl_pkg::OFS_LOWEST, 32'h1);
    wr(frl_pkg::OFS_LOWEST, 32'h7D0);
    rdc(frl_pkg::OFS_LOWEST, 32'h3E8);
    wr(frl_pkg::OFS_LOWEST, 32'h32);
    wr(frl_pkg::OFS_TOP, 32'h64);
    rdc(frl_pkg::OFS_TOP, 32'hFA0);
    wr(frl_pkg::OFS_TOP, 32'hFFFF);
    rdc(frl_pkg::OFS_TOP, 32'h9C40);
    wr(frl_pkg::OFS_TOP, 32'h1770);
    wr(frl_pkg::OFS_KEYPAD, 32'h2000);
    rdc(frl_pkg::OFS_KEYPAD, 32'h1770);
    wr(frl_pkg::OFS_CTRL, 32'h17);
    rdc(frl_pkg::OFS_CTRL, 32'h10);
    wr(frl_pkg::OFS_WIN_HI, 32'h1000);
    wr(frl_pkg::OFS_NOMINAL, 32'h1500);
    rdc(frl_pkg::OFS_NOMINAL, 32'h1500);
    wr(frl_pkg::OFS_KEYPAD, 32'h1500);
    rdc(frl_pkg::OFS_KEYPAD, 32'h1000);
  endtask
  task automatic t_chain;
    refc(16'hFFFF, 32'h1000);
    wr(frl_pkg::OFS_WIN_LO, 32'h100);
    refc(16'h80, 32'h100);
    wr(frl_pkg::OFS_CTRL, 32'h0);
    refc(16'h80, 32'h80);
    refc(16'h20, 32'h0);
    wr(frl_pkg::OFS_CTRL, 32'h80);
    wr(frl_pkg::OFS_KEYPAD, 32'h9000);
    refc(16'h20, 32'h1770);
    wr(frl_pkg::OFS_KEYPAD, 32'h10);
    refc(16'h20, 32'h0);
  endtask
  task automatic t_jump;
    wr(frl_pkg::OFS_CTRL, 32'h20);
    refc(16'h300, 32'h300);
    refc(16'h4B0, 32'h3E8);
    refc(16'h600, 32'h600);
    refc(16'h500, 32'h5DC);
    refc(16'h800, 32'h7D0);
    refc(16'hC00, 32'hBB8);
    refc(16'h100, 32'h100);
    wr(frl_pkg::OFS_WIN_HI, 32'h500);
    wr(frl_pkg::OFS_CTRL, 32'h30);
    refc(16'h700, 32'h3E8);
    wr(frl_pkg::OFS_CTRL, 32'h0);
    wr(frl_pkg::OFS_WIN_HI, 32'h1770);
    ext_ref_in <= 16'h40;
  endtask
  task automatic t_ramp;
    run_in <= 1'b1;
    cyc(2);
    chk({31'h0, drive_en_out}, 32'h1);
    waitf(16'h40, 400);
    run_in <= 1'b0;
    cyc(3);
    chk({31'h0, decel_out}, 32'h1);
    waitf(16'h0, 400);
    cyc(2);
    chk({31'h0, drive_en_out}, 32'h0);
    wr(frl_pkg::OFS_CTRL, 32'h2);
    run_in <= 1'b1;
    waitf(16'h40, 400);
    run_in <= 1'b0;
    cyc(2);
    chk({15'h0, drive_en_out, out_freq_out}, 32'h0);
  endtask
  task automatic t_brake;
    wr(frl_pkg::OFS_CTRL, 32'h44);
    run_in <= 1'b1;
    waitf(16'h40, 400);
    regen <= 1'b1;
    stall_en <= 1'b1;
    run_in <= 1'b0;
    waitb(1'b1, 20);
    chk({31'h0, stall_act_out}, 32'h0);
    regen <= 1'b0;
    waitb(1'b0, 20);
    stall_en <= 1'b0;
    waitf(16'h0, 600);
    cyc(3);
    wr(frl_pkg::OFS_CTRL, 32'h104);
    run_in <= 1'b1;
    waitf(16'h40, 400);
    regen <= 1'b1;
    run_in <= 1'b0;
    cyc(60);
    chk({31'h0, out_freq_out > 16'h40}, 32'h1);
    regen <= 1'b0;
    waitf(16'h0, 800);
    wr(frl_pkg::OFS_CTRL, 32'h22);
    ext_ref_in <= 16'h600;
    run_in <= 1'b1;
    waitf(16'h600, 6400);
    run_in <= 1'b0;
    cyc(2);
    chk({15'h0, drive_en_out, out_freq_out}, 32'h0);
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(12);
    arst_n_in <= 1'b1;
    cyc(1);
    t_defaults;
    t_clamps;
    t_chain;
    t_jump;
    t_ramp;
    t_brake;
    print_verdict;
  end
endmodule
